// ==== ebwic_pkg.sv ====
/*
  Shared constants and carriers for the external bus wait and idle controller.
  Assumes a single 125 MHz system clock; register block sits on a plain strobe port.
*/
`default_nettype none
package ebwic_pkg;
    localparam int AREAS = 8;
    localparam logic [3:0] OFS_WIDTH    = 4'h0;
    localparam logic [3:0] OFS_THREE    = 4'h1;
    localparam logic [3:0] OFS_WAIT_LO  = 4'h2;
    localparam logic [3:0] OFS_WAIT_HI  = 4'h3;
    localparam logic [3:0] OFS_CTRL     = 4'h4;
    localparam logic [3:0] OFS_STATUS   = 4'h5;
    localparam int CTRL_RDN      = 0;
    localparam int CTRL_STRETCH  = 1;
    localparam int CTRL_IDLE_WR  = 2;
    localparam int CTRL_COND_LO  = 3;
    localparam int CTRL_COND_HI  = 4;
    localparam int CTRL_IDLE_LEN = 5;
    localparam int CTRL_BURST_EN = 6;
    localparam logic [7:0]  RST_WIDTH = 8'h00;
    localparam logic [7:0]  RST_THREE = 8'hFF;
    localparam logic [15:0] RST_WAIT_LO = 16'hFFFF;
    localparam logic [7:0]  RST_WAIT_HI = 8'hFF;
    localparam logic [7:0]  RST_CTRL  = 8'h00;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  area;
        logic        dram;
        logic        burst;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebwic_req_s;

    typedef struct packed {
        logic        cs_n;
        logic        as_n;
        logic        rd_n;
        logic        upper_write_strobe_n;
        logic        lower_write_strobe_n;
        logic [23:0] addr;
        logic [15:0] dout;
        logic        dout_en;
    } ebwic_pins_s;
endpackage : ebwic_pkg
`default_nettype wire

// ==== ebwic_ctrl.sv ====
/*
  External basic bus controller: per-area width, 2/3-state cycles, wait states,
  read negation point, select stretch states and idle insertion after DRAM accesses.
  Assumes the requester holds req_i until done_o; data input pins come from outside.
  One state equals two mclk cycles so that a half state can be expressed.
*/
// The address map and the plain strobed port are this design's own decisions.
//
// Contract
// - Per area: width bit set gives 8-bit bus, three-state bit set gives 3-state cycles.
// - Read strobe releases at cycle end or one half-state earlier, per read negation control.
// - Stretch control adds states with only select, address strobe and address asserted.
// - Idle enable after DRAM write inserts idle before a following normal-space read.
// - That idle length follows only the idle-length bit, not the burst-read enable.
// - Idle after continuous synchronous DRAM reads only when burst-read idle enable is 1.
// - Burst-read idle conditions from two select bits, length from idle-length bit.
`timescale 1ns/1ns
`default_nettype none
module ebwic_ctrl (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [3:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic [15:0]               reg_rdata_o,
    input  wire ebwic_pkg::ebwic_req_s req_i,
    output logic                      done_o,
    output logic [15:0]               rdata_o,
    input  wire logic [15:0]          data_pin_i,
    output ebwic_pkg::ebwic_pins_s    pins_o
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_GAP  = 6'b00_0010,
        ST_PRE  = 6'b00_0100,
        ST_ACC  = 6'b00_1000,
        ST_POST = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } ebwic_st_e;

    logic [7:0]  width_sel;
    logic [7:0]  three_sel;
    logic [15:0] wait_lo;
    logic [7:0]  wait_hi;
    logic [7:0]  ctrl;
    ebwic_st_e   st;
    logic [4:0]  cnt;
    logic [4:0]  acc_len;
    logic        last_dram_wr;
    logic        last_burst_rd;
    logic [15:0] sync_a;
    logic [15:0] sync_b;
    logic [2:0]  wait_n;
    logic        need_idle;
    logic        area8;
    logic        area3;
    logic        req_new;
    logic        wr_phase;

    localparam int CTRL_IDLE_WR_L = ebwic_pkg::CTRL_IDLE_WR;
    localparam int CTRL_BURST_L   = ebwic_pkg::CTRL_BURST_EN;
    localparam int CTRL_COND_HI_L = ebwic_pkg::CTRL_COND_HI;
    localparam int CTRL_COND_LO_L = ebwic_pkg::CTRL_COND_LO;

    assign area8  = width_sel[req_i.area];
    assign area3  = three_sel[req_i.area];
    assign wait_n = {wait_hi[req_i.area], wait_lo[2*req_i.area+1], wait_lo[2*req_i.area]};
    // Each state is two mclk cycles; 2-state cycles ignore the wait field.
    assign acc_len = area3 ? 5'(6 + 2 * wait_n) : 5'd4;
    // The write strobe lifts one mclk before the access ends so data hold is met at the device.
    assign wr_phase = (st == ST_ACC) && req_i.write && (cnt != acc_len - 5'd1);
    // A new request is taken only once the done pulse has gone, because the requester
    // can drop valid no earlier than the edge that follows done_o.
    assign req_new = req_i.valid && !done_o;

    // The burst-read idle uses the two condition bits: lo demands a following read,
    // hi allows any normal access; either set with enable on inserts idle.
    always_comb begin
        need_idle = 1'b0;
        if (!req_i.dram && ctrl[CTRL_IDLE_WR_L] && last_dram_wr && !req_i.write) begin
            need_idle = 1'b1;
        end else if (!req_i.dram && ctrl[CTRL_BURST_L] && last_burst_rd) begin
            need_idle = ctrl[CTRL_COND_HI_L] || (ctrl[CTRL_COND_LO_L] && !req_i.write);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            width_sel <= ebwic_pkg::RST_WIDTH;
            three_sel <= ebwic_pkg::RST_THREE;
            wait_lo   <= ebwic_pkg::RST_WAIT_LO;
            wait_hi   <= ebwic_pkg::RST_WAIT_HI;
            ctrl      <= ebwic_pkg::RST_CTRL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ebwic_pkg::OFS_WIDTH) begin
                width_sel <= reg_wdata_i[7:0];
            end else if (reg_addr_i == ebwic_pkg::OFS_THREE) begin
                three_sel <= reg_wdata_i[7:0];
            end else if (reg_addr_i == ebwic_pkg::OFS_WAIT_LO) begin
                wait_lo <= reg_wdata_i;
            end else if (reg_addr_i == ebwic_pkg::OFS_WAIT_HI) begin
                wait_hi <= reg_wdata_i[7:0];
            end else if (reg_addr_i == ebwic_pkg::OFS_CTRL) begin
                ctrl <= reg_wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == ebwic_pkg::OFS_WIDTH) begin
                reg_rdata_o <= {8'h00, width_sel};
            end else if (reg_addr_i == ebwic_pkg::OFS_THREE) begin
                reg_rdata_o <= {8'h00, three_sel};
            end else if (reg_addr_i == ebwic_pkg::OFS_WAIT_LO) begin
                reg_rdata_o <= wait_lo;
            end else if (reg_addr_i == ebwic_pkg::OFS_WAIT_HI) begin
                reg_rdata_o <= {8'h00, wait_hi};
            end else if (reg_addr_i == ebwic_pkg::OFS_CTRL) begin
                reg_rdata_o <= {8'h00, ctrl};
            end else if (reg_addr_i == ebwic_pkg::OFS_STATUS) begin
                reg_rdata_o <= {8'h00, 2'b00, st};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Data pins come from the outside world and pass two flops before use.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 16'h0000;
            sync_b <= 16'h0000;
        end else begin
            sync_a <= data_pin_i;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st  <= ST_IDLE;
            cnt <= 5'd0;
        end else begin
            case (st)
                ST_IDLE: begin
                    cnt <= 5'd0;
                    if (req_new && !req_i.dram) begin
                        if (need_idle) begin
                            st <= ST_GAP;
                        end else if (ctrl[ebwic_pkg::CTRL_STRETCH]) begin
                            st <= ST_PRE;
                        end else begin
                            st <= ST_ACC;
                        end
                    end else if (req_new) begin
                        st <= ST_DONE;
                    end
                end
                ST_GAP: begin
                    // Idle length: one state, or two with the length bit set.
                    if (cnt == (ctrl[ebwic_pkg::CTRL_IDLE_LEN] ? 5'd3 : 5'd1)) begin
                        cnt <= 5'd0;
                        st  <= ctrl[ebwic_pkg::CTRL_STRETCH] ? ST_PRE : ST_ACC;
                    end else begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ST_PRE: begin
                    if (cnt == 5'd1) begin
                        cnt <= 5'd0;
                        st  <= ST_ACC;
                    end else begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ST_ACC: begin
                    if (cnt == acc_len - 5'd1) begin
                        cnt <= 5'd0;
                        st  <= ctrl[ebwic_pkg::CTRL_STRETCH] ? ST_POST : ST_DONE;
                    end else begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ST_POST: begin
                    if (cnt == 5'd1) begin
                        cnt <= 5'd0;
                        st  <= ST_DONE;
                    end else begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ST_DONE: begin
                    st <= ST_IDLE;
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    // History of the previous access decides idle insertion for the next.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_dram_wr  <= 1'b0;
            last_burst_rd <= 1'b0;
        end else if (st == ST_DONE) begin
            last_dram_wr  <= req_i.dram && req_i.write;
            last_burst_rd <= req_i.dram && req_i.burst && !req_i.write;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (st == ST_DONE);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (st == ST_ACC && !req_i.write && cnt == acc_len - 5'd1) begin
            // Sampling at the last access cycle relies on the device holding data by then.
            rdata_o <= area8 ? {8'h00, sync_b[15:8]} : sync_b;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o <= '{cs_n: 1'b1, as_n: 1'b1, rd_n: 1'b1, upper_write_strobe_n: 1'b1,
                        lower_write_strobe_n: 1'b1, addr: 24'h00_0000, dout: 16'h0000, dout_en: 1'b0};
        end else begin
            pins_o.addr   <= req_i.addr;
            pins_o.cs_n   <= !(st == ST_PRE || st == ST_ACC || st == ST_POST);
            pins_o.as_n   <= !(st == ST_PRE || st == ST_ACC || st == ST_POST);
            // Strobes only inside the access; stretch states keep them high.
            if (st == ST_ACC && !req_i.write) begin
                // Early negation lifts the strobe a half state, which is one mclk, before the end.
                pins_o.rd_n <= ctrl[ebwic_pkg::CTRL_RDN] && (cnt == acc_len - 5'd1);
            end else begin
                pins_o.rd_n <= 1'b1;
            end
            pins_o.upper_write_strobe_n <= !wr_phase;
            pins_o.lower_write_strobe_n <= !(wr_phase && !area8);
            pins_o.dout    <= req_i.wdata;
            pins_o.dout_en <= (st == ST_ACC) && req_i.write;
        end
    end
endmodule : ebwic_ctrl
`default_nettype wire

// ==== ebwic_ctrl_assertions.sv ====
/*
  Port assertions for the external bus controller.
  Assumes it is bound to ebwic_ctrl and that control values are not changed during an access.
*/
`timescale 1ns/1ns
`default_nettype none
module ebwic_ctrl_checker (
    input wire logic                   mclk_i,
    input wire logic                   rst_n_i,
    input wire logic [3:0]             reg_addr_i,
    input wire logic [15:0]            reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire ebwic_pkg::ebwic_req_s  req_i,
    input wire logic                   done_o,
    input wire ebwic_pkg::ebwic_pins_s pins_o
);
    logic [7:0] wid;
    logic [7:0] thr;
    logic [7:0] ctl;
    logic       dwr;
    logic       brd;
    // Shadows follow register writes only, because the register file itself is hidden.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wid <= ebwic_pkg::RST_WIDTH;
            thr <= ebwic_pkg::RST_THREE;
            ctl <= ebwic_pkg::RST_CTRL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ebwic_pkg::OFS_WIDTH) wid <= reg_wdata_i[7:0];
            if (reg_addr_i == ebwic_pkg::OFS_THREE) thr <= reg_wdata_i[7:0];
            if (reg_addr_i == ebwic_pkg::OFS_CTRL) ctl <= reg_wdata_i[7:0];
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dwr <= 1'b0;
            brd <= 1'b0;
        end else if (done_o) begin
            dwr <= req_i.dram && req_i.write;
            brd <= req_i.dram && req_i.burst && !req_i.write;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    byte_lane_a: assert property (!pins_o.lower_write_strobe_n |-> !wid[req_i.area])
        else $error("low lane on byte area");
    two_state_a: assert property ($fell(pins_o.rd_n) && !thr[req_i.area] && !ctl[0] |=>
        !pins_o.rd_n [*3] ##1 pins_o.rd_n) else $error("two-state strobe length");
    early_neg_a: assert property ($fell(pins_o.rd_n) && !thr[req_i.area] && ctl[0] |=>
        !pins_o.rd_n [*2] ##1 pins_o.rd_n) else $error("early negation length");
    strobe_sel_a: assert property (!pins_o.rd_n |-> !pins_o.cs_n && !pins_o.as_n
        && pins_o.upper_write_strobe_n)
        else $error("read strobe outside select");
    stretch_quiet_a: assert property ($fell(pins_o.cs_n) && ctl[1] |->
        (pins_o.rd_n && pins_o.upper_write_strobe_n && pins_o.lower_write_strobe_n) [*2])
        else $error("strobe in stretch state");
    idle_short_a: assert property ($rose(req_i.valid) && !req_i.dram && !req_i.write && dwr && ctl[2]
        && !ctl[5] && !ctl[1] |-> pins_o.cs_n [*4] ##1 !pins_o.cs_n) else $error("short idle wrong");
    idle_long_a: assert property ($rose(req_i.valid) && !req_i.dram && !req_i.write && dwr && ctl[2]
        && ctl[5] && !ctl[1] |-> pins_o.cs_n [*6] ##1 !pins_o.cs_n) else $error("long idle wrong");
    burst_off_a: assert property ($rose(req_i.valid) && !req_i.dram && brd && !ctl[6] && !dwr && !ctl[1]
        |-> pins_o.cs_n [*2] ##1 !pins_o.cs_n) else $error("idle while disabled");
    burst_on_a: assert property ($rose(req_i.valid) && !req_i.dram && brd && ctl[6] && !dwr && !ctl[1]
        && !ctl[5] && (ctl[4] || (ctl[3] && !req_i.write)) |-> pins_o.cs_n [*4] ##1 !pins_o.cs_n)
        else $error("burst idle wrong");
endmodule : ebwic_ctrl_checker
bind ebwic_ctrl ebwic_ctrl_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .req_i(req_i), .done_o(done_o), .pins_o(pins_o));
`default_nettype wire

// ==== ebwic_mem_model.sv ====
/*
  External memory on the basic bus: sixteen words indexed by the low address bits.
  Assumes active-low select and strobes from the controller pins.
*/
`timescale 1ns/1ns
`default_nettype none
module ebwic_mem_model (
    input wire logic                   mclk_i,
    input wire ebwic_pkg::ebwic_pins_s pins_i,
    output logic [15:0]                data_o
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    // A released bus shows the inverse of the last word, so a late sample cannot pass by luck.
    assign data_o = (!pins_i.cs_n && !pins_i.rd_n) ? mem[pins_i.addr[3:0]] : ~last;
    always @(posedge mclk_i) begin
        if (!pins_i.cs_n && !pins_i.rd_n) last <= data_o;
        if (!pins_i.cs_n && !pins_i.upper_write_strobe_n) mem[pins_i.addr[3:0]][15:8] <= pins_i.dout[15:8];
        if (!pins_i.cs_n && !pins_i.lower_write_strobe_n) mem[pins_i.addr[3:0]][7:0] <= pins_i.dout[7:0];
    end
endmodule : ebwic_mem_model
`default_nettype wire

// ==== test_external_bus_wait_idle_ctrl.sv ====
/*
  Bench for ebwic_ctrl: register tasks and an access task that counts cycles to done.
  Assumes the memory model answers every normal-space access.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module test_external_bus_wait_idle_ctrl;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, done;
    logic [3:0] adr = 4'h0;
    logic [15:0] wd = 16'h0000, rdat, regd, dpin;
    ebwic_pkg::ebwic_req_s req = '0;
    ebwic_pkg::ebwic_pins_s pins;
    int err_count = 0, num_checks = 0;
    initial forever #4 clk = ~clk;
    ebwic_ctrl u_dut (.mclk_i(clk), .rst_n_i(rst_n), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(regd), .req_i(req), .done_o(done), .rdata_o(rdat), .data_pin_i(dpin),
        .pins_o(pins));
    ebwic_mem_model u_mem (.mclk_i(clk), .pins_i(pins), .data_o(dpin));
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        adr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
        adr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(negedge clk) `CHK(n, e, regd)
        @(posedge clk);
    endtask : rd
    task automatic acc(input logic w, input logic [2:0] ar, input logic dm, input logic b,
                       input logic [15:0] d, input int n, input string nm);
        int c;
        c = 0;
        req <= '{1'b1, w, ar, dm, b, {21'h0, ar}, d};
        do begin
            @(posedge clk) c++;
            @(negedge clk);
        end while (!done && c < 60);
        if (!done) begin
            err_count++;
            give_verdict;
        end
        `CHK(nm, n, c)
        if (!w && !dm) `CHK(nm, d, rdat)
        @(posedge clk) req.valid <= 1'b0;
        @(posedge clk);
        $display("test %s done", nm);
    endtask : acc
    task automatic burst2;
        acc(0, 3, 1, 1, 16'h0000, 2, "brd");
        acc(0, 3, 1, 1, 16'h0000, 2, "brd");
    endtask : burst2
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ebwic_pkg::OFS_THREE, {8'h00, ebwic_pkg::RST_THREE}, "three");
        rd(ebwic_pkg::OFS_CTRL, 16'h0000, "ctrl");
        rd(4'hF, 16'h0000, "unmapped");
        wr(ebwic_pkg::OFS_WIDTH, 16'h0002);
        wr(ebwic_pkg::OFS_THREE, 16'h0004);
        wr(ebwic_pkg::OFS_WAIT_LO, 16'h0030);
        wr(ebwic_pkg::OFS_WAIT_HI, 16'h0000);
        rd(ebwic_pkg::OFS_WIDTH, 16'h0002, "width");
        acc(1, 0, 0, 0, 16'hA5C3, 6, "wr16");
        acc(0, 0, 0, 0, 16'hA5C3, 6, "rd16");
        acc(1, 1, 0, 0, 16'h5A00, 6, "wr8");
        acc(0, 1, 0, 0, 16'h005A, 6, "rd8");
        acc(1, 2, 0, 0, 16'h3C5A, 14, "wr3s");
        acc(0, 2, 0, 0, 16'h3C5A, 14, "rd3s");
        wr(ebwic_pkg::OFS_CTRL, 16'h0001);
        acc(0, 0, 0, 0, 16'hA5C3, 6, "early");
        wr(ebwic_pkg::OFS_CTRL, 16'h0002);
        acc(0, 0, 0, 0, 16'hA5C3, 10, "str_rd");
        acc(1, 0, 0, 0, 16'hA5C3, 10, "str_wr");
        wr(ebwic_pkg::OFS_CTRL, 16'h0004);
        acc(1, 3, 1, 0, 16'h0000, 2, "dwr");
        acc(0, 0, 0, 0, 16'hA5C3, 8, "idle1");
        wr(ebwic_pkg::OFS_CTRL, 16'h0064);
        acc(1, 3, 1, 0, 16'h0000, 2, "dwr");
        acc(0, 0, 0, 0, 16'hA5C3, 10, "idle2");
        wr(ebwic_pkg::OFS_CTRL, 16'h0050);
        burst2;
        acc(1, 0, 0, 0, 16'hA5C3, 8, "b_any");
        wr(ebwic_pkg::OFS_CTRL, 16'h0048);
        burst2;
        acc(1, 0, 0, 0, 16'hA5C3, 6, "b_lo_wr");
        burst2;
        acc(0, 0, 0, 0, 16'hA5C3, 8, "b_lo_rd");
        wr(ebwic_pkg::OFS_CTRL, 16'h0010);
        burst2;
        acc(0, 0, 0, 0, 16'hA5C3, 6, "b_off");
        give_verdict;
    end
endmodule : test_external_bus_wait_idle_ctrl
`default_nettype wire
